//--- rtl/pdpc_pkg.sv
/*
 * Package for the dynamic phase control block of the clock generator.
 * Assumes a single 250 MHz core clock and synchronous active-high reset.
 */
package pdpc_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_PS    = 4000;
   localparam int LOCK_TIME_NS     = 50000;
   localparam int LOCK_CYCLES      = (LOCK_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int LOCK_CNT_W       = 16;
   // Phase layout
   localparam int NUM_OUTPUTS      = 4;
   localparam int PHASE_W          = 3;
   localparam int SEL_W            = 2;
   localparam int FB_OUTPUT        = 0;
   localparam logic [PHASE_W-1:0] PHASE_RESET = 3'h0;
   // Settings word layout
   localparam int WB_ADDR_W        = 8;
   localparam int WB_DATA_W        = 8;
   localparam int NUM_SETTINGS     = 8;
   localparam int SET_IDX_W        = 3;
   localparam logic [WB_DATA_W-1:0] SETTING_RESET = 8'h01;

   // Dynamic phase request from user logic
   typedef struct packed {
      logic [SEL_W-1:0] sel;
      logic             dir;
   } pdpc_phase_req_type;

   // Lock tracking states, Gray coded
   typedef enum logic [1:0] {
      PDPC_LOCKED   = 2'b00,
      PDPC_SETTLING = 2'b01
   } pdpc_lock_type;
endpackage : pdpc_pkg

//--- rtl/pdpc_top.sv
/*
 * Behavioural model of the clock generator dynamic control: phase stepping,
 * reference switching, settings port, and lock tracking.
 * Assumes all control inputs except the pin-level step toggle, reference
 * select and the reference and feedback clocks are synchronous to
 * core_clk_in; those pass three flip-flops first.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - Phase fixed at reset or changed dynamically
// - Two-bit select picks the adjusted output
// - Direction input chooses forward or backward
// - Each step toggle moves one step
// - Feedback output step may drop lock
// - Reference switchable between two sources
// - Settings port rewrites dividers at run time
// - Settings rewrite may drop lock
module pdpc_top
   import pdpc_pkg::*;
#(
   parameter int LOCK_TIME_CYCLES = LOCK_CYCLES
) (
   input  wire logic                  core_clk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic                  pll_ref_clock_in,
   input  wire logic                  pll_ref_clock_alt_in,
   input  wire logic                  pll_feedback_clock_in,
   input  wire logic                  ref_select_in,
   input  wire pdpc_phase_req_type    phase_req_in,
   input  wire logic                  phase_step_toggle_in,
   input  wire logic                  wb_cyc_in,
   input  wire logic                  wb_stb_in,
   input  wire logic                  wb_we_in,
   input  wire logic [WB_ADDR_W-1:0]  wb_adr_in,
   input  wire logic [WB_DATA_W-1:0]  wb_dat_in,
   output logic      [WB_DATA_W-1:0]  wb_dat_out,
   output logic                       wb_ack_out,
   output logic [NUM_OUTPUTS*PHASE_W-1:0] phase_out,
   output logic                       ref_active_out,
   output logic                       pll_lock_out
);

   // Step toggle and reference select come from pins: three-stage sync
   logic [2:0] step_sync;
   logic [2:0] refsel_sync;
   logic [2:0] next_step_sync;
   logic [2:0] next_refsel_sync;
   logic       step_seen;
   logic       next_step_seen;
   logic       fb_seen;
   logic       next_fb_seen;
   logic [2:0] refclk_sync;
   logic [2:0] next_refclk_sync;
   logic [2:0] fbclk_sync;
   logic [2:0] next_fbclk_sync;

   // Phase state
   logic [PHASE_W-1:0] phase_reg [NUM_OUTPUTS];
   logic [PHASE_W-1:0] next_phase [NUM_OUTPUTS];
   logic               ref_active;
   logic               next_ref_active;

   // Settings store
   logic [WB_DATA_W-1:0] setting [NUM_SETTINGS];
   logic [WB_DATA_W-1:0] next_setting [NUM_SETTINGS];
   logic [WB_DATA_W-1:0] next_wb_dat;
   logic                 next_wb_ack;

   // Lock tracking
   pdpc_lock_type        lock_state;
   pdpc_lock_type        next_lock_state;
   logic [LOCK_CNT_W-1:0] lock_cnt;
   logic [LOCK_CNT_W-1:0] next_lock_cnt;
   logic                 next_lock;
   logic                 step_evt;
   logic                 ref_evt;
   logic                 wr_evt;
   logic                 fb_step;

   // Settling length limited to one cycle minimum
   function automatic logic [LOCK_CNT_W-1:0] settle_len(input int cyc);
      settle_len = (cyc < 1) ? LOCK_CNT_W'(1) : LOCK_CNT_W'(cyc);
   endfunction : settle_len

   // Synchronisers; toggles counted once stages two and three agree
   always_comb begin
      next_step_sync   = {step_sync[1:0], phase_step_toggle_in};
      next_refsel_sync = {refsel_sync[1:0], ref_select_in};
      // Activity is judged against the reference now in use
      next_refclk_sync = {refclk_sync[1:0],
                          ref_active ? pll_ref_clock_alt_in
                                     : pll_ref_clock_in};
      next_fbclk_sync  = {fbclk_sync[1:0], pll_feedback_clock_in};
      // Seen level moves only on a settled change, so a glitch
      // that never settles cannot come back as a false step
      next_step_seen   = step_evt ? step_sync[2] : step_seen;
      next_fb_seen     = fb_seen |
                         (fbclk_sync[2] ^ refclk_sync[2]);
      if (sys_rst_in) begin
         next_refsel_sync = 3'h0;
         next_refclk_sync = 3'h0;
         next_fbclk_sync  = 3'h0;
         // Step pin keeps shifting in reset; seen level seeded from it
         // so a pin left high gives no false step after release
         next_step_seen   = step_sync[2];
         next_fb_seen     = 1'b0;
      end
   end

   // Events: step on toggle, reference switch, settings write
   always_comb begin
      step_evt = (step_sync[2] == step_sync[1]) &&
                 (step_sync[2] != step_seen);
      ref_evt  = (refsel_sync[2] == refsel_sync[1]) &&
                 (refsel_sync[2] != ref_active);
      wr_evt   = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
      fb_step  = step_evt &&
                 (phase_req_in.sel == SEL_W'(FB_OUTPUT));
   end

   // Phase adjust of the selected output, one step per toggle
   always_comb begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
         next_phase[i] = phase_reg[i];
      end
      if (step_evt) begin
         if (phase_req_in.dir) begin
            next_phase[phase_req_in.sel] =
               phase_reg[phase_req_in.sel] - PHASE_W'(1);
         end else begin
            next_phase[phase_req_in.sel] =
               phase_reg[phase_req_in.sel] + PHASE_W'(1);
         end
      end
      next_ref_active = ref_evt ? refsel_sync[2] : ref_active;
      if (sys_rst_in) begin
         for (int i = 0; i < NUM_OUTPUTS; i++) begin
            next_phase[i] = PHASE_RESET;
         end
         next_ref_active = 1'b0;
      end
   end

   // Settings port: single-cycle ack, unmapped reads as zero
   always_comb begin
      for (int i = 0; i < NUM_SETTINGS; i++) begin
         next_setting[i] = setting[i];
      end
      next_wb_ack = wb_cyc_in && wb_stb_in && !wb_ack_out;
      next_wb_dat = '0;
      if (wb_adr_in < WB_ADDR_W'(NUM_SETTINGS)) begin
         next_wb_dat = setting[wb_adr_in[SET_IDX_W-1:0]];
         if (wr_evt) begin
            next_setting[wb_adr_in[SET_IDX_W-1:0]] = wb_dat_in;
         end
      end
      if (sys_rst_in) begin
         for (int i = 0; i < NUM_SETTINGS; i++) begin
            next_setting[i] = SETTING_RESET;
         end
         next_wb_ack = 1'b0;
         next_wb_dat = '0;
      end
   end

   // Lock drops on disturbance and returns after the lock time
   always_comb begin
      next_lock_state = lock_state;
      next_lock_cnt   = lock_cnt;
      if (fb_step || ref_evt || wr_evt) begin
         next_lock_state = PDPC_SETTLING;
         next_lock_cnt   = settle_len(LOCK_TIME_CYCLES);
      end else begin
         case (lock_state)
            PDPC_SETTLING: begin
               if (lock_cnt <= LOCK_CNT_W'(1)) begin
                  next_lock_cnt = '0;
                  if (fb_seen) begin
                     next_lock_state = PDPC_LOCKED;
                  end
               end else begin
                  next_lock_cnt = lock_cnt - LOCK_CNT_W'(1);
               end
            end
            default: begin
               next_lock_state = PDPC_LOCKED;
            end
         endcase
      end
      if (sys_rst_in) begin
         next_lock_state = PDPC_SETTLING;
         next_lock_cnt   = settle_len(LOCK_TIME_CYCLES);
      end
      next_lock = (next_lock_state == PDPC_LOCKED);
   end

   // Synchroniser and event-tracking registers
   always_ff @(posedge core_clk_in) begin
      step_sync   <= next_step_sync;
      refsel_sync <= next_refsel_sync;
      refclk_sync <= next_refclk_sync;
      fbclk_sync  <= next_fbclk_sync;
      step_seen   <= next_step_seen;
      fb_seen     <= next_fb_seen;
   end

   // Phase and reference registers
   always_ff @(posedge core_clk_in) begin
      phase_reg      <= next_phase;
      ref_active     <= next_ref_active;
      ref_active_out <= next_ref_active;
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
         phase_out[i*PHASE_W +: PHASE_W] <= next_phase[i];
      end
   end

   // Settings port registers
   always_ff @(posedge core_clk_in) begin
      setting    <= next_setting;
      wb_ack_out <= next_wb_ack;
      wb_dat_out <= next_wb_dat;
   end

   // Lock tracking registers; lock is low in reset via the state
   always_ff @(posedge core_clk_in) begin
      lock_state   <= next_lock_state;
      lock_cnt     <= next_lock_cnt;
      pll_lock_out <= next_lock;
   end

endmodule : pdpc_top

//--- tb/pdpc_checker.sv
/* Port checker for pdpc_top.
   Bound from the testbench; sees only top ports. */
`timescale 1ns/1ps
module pdpc_checker
   import pdpc_pkg::*;
(
   input wire logic        core_clk_in,
   input wire logic        sys_rst_in,
   input wire logic        phase_step_toggle_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic        wb_ack_out,
   input wire logic [11:0] phase_out,
   input wire logic        ref_active_out,
   input wire logic        pll_lock_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   // Bus, lock and phase relations
   ack_resp_a: assert property (
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack");
   ack_pulse_a: assert property (
      wb_ack_out |=> !wb_ack_out) else $error("ack long");
   write_lock_a: assert property (
      wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out |=> !pll_lock_out)
      else $error("lock kept");
   ref_drop_a: assert property (
      $changed(ref_active_out) |-> ##[0:1] !pll_lock_out) else $error("ref");
   phase_quiet_a: assert property (
      $stable(phase_step_toggle_in) [*6] |=> $stable(phase_out))
      else $error("phase moved");
   fb_drop_a: assert property (
      $changed(phase_out[2:0]) |-> !pll_lock_out) else $error("fb lock");
   lock_hold_a: assert property (
      $fell(pll_lock_out) |=> !pll_lock_out [*8]) else $error("relock");
   lock_rise_a: assert property (
      $rose(pll_lock_out) |-> !$past(pll_lock_out, 16)) else $error("early");
   // Main scenarios
   cov_wr: cover property (wb_we_in && wb_ack_out);
   cov_ph: cover property ($changed(phase_out));
   cov_lk: cover property ($rose(pll_lock_out));
   cov_rf: cover property ($changed(ref_active_out));
endmodule : pdpc_checker

//--- tb/pdpc_partner.sv
/* Clock sources outside the block: two references and feedback.
   Free running; needs no reset. */
`timescale 1ns/1ps
module pdpc_partner (
   output logic ref_clk_out,
   output logic alt_clk_out,
   output logic fb_clk_out
);
   // Two unrelated references
   initial begin
      ref_clk_out = 1'b0;
      alt_clk_out = 1'b0;
      fork
         forever #5 ref_clk_out = ~ref_clk_out;
         forever #7 alt_clk_out = ~alt_clk_out;
      join
   end
   // Feedback returns half a period late
   assign fb_clk_out = ~ref_clk_out;
endmodule : pdpc_partner

//--- tb/testbench.sv
/* Self-checking bench for pdpc_top: settings, steps, reference, lock.
   Reference and feedback clocks come from pdpc_partner. */
`timescale 1ns/1ps
module testbench
   import pdpc_pkg::*;
;
   logic clk, rst, rs, tg, cyc, stb, we, ack, lk, ra;
   logic [7:0]  adr, wd, rd, rdat;
   logic [11:0] ph;
   logic [2:0]  ex [4] = '{default: 3'h0};
   wire rc, ac, fc;
   pdpc_phase_req_type req;
   int errors, n_tests;
   pdpc_partner far (.ref_clk_out(rc), .alt_clk_out(ac), .fb_clk_out(fc));
   pdpc_top #(.LOCK_TIME_CYCLES(20)) uut (.core_clk_in(clk),
      .sys_rst_in(rst), .pll_ref_clock_in(rc), .pll_ref_clock_alt_in(ac),
      .pll_feedback_clock_in(fc), .ref_select_in(rs), .phase_req_in(req),
      .phase_step_toggle_in(tg), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wd), .wb_dat_out(rd),
      .wb_ack_out(ack), .phase_out(ph), .ref_active_out(ra),
      .pll_lock_out(lk));
   // Core clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic close_out;
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic check(input logic [11:0] s, input logic [11:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   // One bus cycle on the settings port, held through the
   // rising edge that samples ack high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      {cyc, stb, we, adr, wd} = {2'b11, w, a, d};
      for (int i = 0; i < 8 && ack !== 1'b1; i++) @(negedge clk);
      if (ack !== 1'b1) begin
         errors++;
         close_out();
      end
      rdat = rd; // Read data follows the address each cycle, not only with ack
      @(negedge clk);
      {cyc, stb} = 2'b00;
      @(negedge clk);
   endtask : wb
   // Bounded wait for relock
   task automatic wait_lock;
      for (int i = 0; i < 40 && lk !== 1'b1; i++) @(negedge clk);
      check(lk, 1'b1);
      if (lk !== 1'b1) close_out();
   endtask : wait_lock
   task automatic step(input logic [1:0] s, input logic d);
      req = '{s, d}; // Held across the step
      @(negedge clk);
      tg = ~tg;
      repeat (6) @(negedge clk);
      ex[s] = d ? ex[s] - 3'h1 : ex[s] + 3'h1;
      check(ph, {ex[3], ex[2], ex[1], ex[0]});
      if (s == 2'h0) check(lk, 1'b0);
      wait_lock();
   endtask : step
   task automatic t_regs;
      for (int a = 0; a < 9; a++) begin
         wb(1'b0, a[7:0], 8'h00);
         check(rdat, a < 8 ? 8'h01 : 8'h00);
      end
      wb(1'b1, 8'h03, 8'h5a);
      check(lk, 1'b0);
      wb(1'b1, 8'h08, 8'h77);
      wb(1'b0, 8'h03, 8'h00);
      check(rdat, 8'h5a);
      wb(1'b0, 8'h08, 8'h00);
      check(rdat, 8'h00);
      wb(1'b0, 8'h00, 8'h00);
      check(rdat, 8'h01); // Refused write left slot zero
      wait_lock();
   endtask : t_regs
   task automatic t_phase;
      for (int s = 0; s < 4; s++) begin
         step(s[1:0], 1'b1);
         step(s[1:0], 1'b0);
      end
   endtask : t_phase
   task automatic t_ref(input logic v);
      rs = v;
      repeat (6) @(negedge clk);
      check({ra, lk}, {v, 1'b0});
      wait_lock();
   endtask : t_ref
   // Mid-run reset with the step pin left high
   task automatic t_reset;
      step(2'h1, 1'b0);
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      ex = '{default: 3'h0};
      check(ph, 12'h000);
      check({ra, lk}, 2'b00);
      repeat (6) @(negedge clk);
      check(ph, 12'h000); // No false step after release
      wait_lock();
   endtask : t_reset
   // Main sequence
   initial begin
      {errors, n_tests} = '0;
      {rst, rs, tg, cyc, stb, we, adr, wd, req} = '0;
      rst = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      check(ph, 12'h000);
      wait_lock();
      t_regs();
      t_phase();
      t_ref(1'b1);
      t_ref(1'b0);
      t_reset();
      close_out();
   end
endmodule : testbench
bind pdpc_top pdpc_checker chk (.core_clk_in(core_clk_in),
   .sys_rst_in(sys_rst_in), .phase_step_toggle_in(phase_step_toggle_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
   .wb_ack_out(wb_ack_out), .phase_out(phase_out),
   .ref_active_out(ref_active_out), .pll_lock_out(pll_lock_out));
